// ### hw/flash_prog_pkg.sv
// Constants, types and register layout for the user flash program control block.
// Operation
// - Speed fuse zero selects six-clock double speed.
// - Boot-jump fuse picks boot mapping and start address.
// - Lock field bits 2-0, software cannot change.
// - 128-byte page write buffer feeds user, extra row and security writes.
// - Page buffer is write-only to software.
// - User flash programmable only from boot flash code.
// - Boot flash never written by software.
// - Access matrix by executing region enforced.
// - External code reads user flash per lock bits.
// - Write 5x then Ax to launch operation.
// - Control bit 3 steers data-pointer writes to buffer.
// - Busy flag hardware-only, set while programming.
// - Sequence error set on bad launch, cleared later.
// - Loaded flag set on first byte, cleared on success.
// - Registers steer spaces into code or data space.
// - Space select maps user, extra row, security, reset.
// - Launch writes consecutive with same space select.
// - Programming starts second machine cycle after launch.
// - Buffer writes ignored while busy.
`default_nettype none
package flash_prog_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'hd1;
  localparam logic [7:0] ADDR_STATUS = 8'hd3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] KEY_FIRST = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'ha;
  localparam int BUFFER_BYTES = 128;
  localparam int PAGE_BITS = 7;
  localparam logic [1:0] SEL_USER = 2'h0;
  localparam logic [1:0] SEL_EXTRA = 2'h1;
  localparam logic [1:0] SEL_SECURITY = 2'h2;
  localparam logic [1:0] SEL_BUF_RESET = 2'h3;
  localparam logic [15:0] EXTRA_ROW_BASE = 16'hff80;
  localparam logic [15:0] SECURITY_ADDR = 16'h0000;
  localparam logic [15:0] START_USER = 16'h0000;
  localparam logic [15:0] START_BOOT = 16'hf800;
  localparam logic [7:0] SECURITY_WRITABLE = 8'hc0;
  localparam logic [7:0] SECURITY_DEFINED = 8'hc7;
  localparam int CLK_NS = 40;
  localparam int MACHINE_CLOCKS_STD = 12;
  localparam int MACHINE_CLOCKS_DOUBLE = 6;
  localparam int PROGRAM_TIME_NS = 100000;
  localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int LAUNCH_DELAY_MC = 2;
  typedef enum logic [1:0] {
    REGION_USER = 2'h0,
    REGION_BOOT = 2'h1,
    REGION_EXTERNAL = 2'h2
  } region_t;
  typedef struct packed {
    logic [3:0] key;
    logic map_buffer;
    logic [1:0] space_sel;
    logic busy;
  } control_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xdata_req_t;
endpackage
`default_nettype wire

// ### hw/user_flash_program_control.sv
// Flash program sequencer: control and status registers, page buffer and access policing.
`default_nettype none
module user_flash_program_control #(
  parameter int PROGRAM_CYCLES = flash_prog_pkg::PROGRAM_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire flash_prog_pkg::sfr_req_t sfr_req,
  input wire logic instr_boundary,
  input wire logic machine_cycle,
  input wire flash_prog_pkg::region_t exec_region,
  input wire flash_prog_pkg::xdata_req_t xdata_req,
  input wire logic [7:0] security_fuses,
  input wire logic [15:0] code_addr,
  input wire logic [7:0] user_flash_rdata,
  output logic [7:0] sfr_rdata,
  output logic xdata_passthru,
  output logic [7:0] code_rdata,
  output logic code_read_refused,
  output logic double_speed,
  output logic boot_map_enable,
  output logic [15:0] start_addr,
  output logic [2:0] general_lock_field,
  output logic flash_write_strobe,
  output logic [1:0] flash_write_space,
  output logic [8:0] flash_page_addr,
  output logic [7:0] flash_wdata,
  output logic [6:0] flash_wbyte,
  output logic flash_wbyte_valid
);
  localparam int PW = flash_prog_pkg::PAGE_BITS;
  localparam int CW = $clog2(PROGRAM_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // Fuses are sampled on the first clock after reset release, not under the async reset.
  logic fuse_taken_r;
  logic [7:0] fuse_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fuse_taken_r <= 1'b0;
      fuse_r <= 8'hff;
    end else if (!fuse_taken_r) begin
      fuse_taken_r <= 1'b1;
      fuse_r <= security_fuses;
    end
  end
  wire fuse_x2 = fuse_r[7];
  wire fuse_jump = fuse_r[6];

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_PROG = 3'b100
  } seq_state_t;
  seq_state_t state_r;
  flash_prog_pkg::control_t ctrl_r;
  logic seq_err_r;
  logic loaded_r;
  logic armed_r;
  logic [1:0] armed_sel_r;
  logic [1:0] op_sel_r;
  logic [1:0] mc_cnt_r;
  logic [CW-1:0] prog_cnt_r;
  logic [7:0] buf_data_r [flash_prog_pkg::BUFFER_BYTES];
  logic [flash_prog_pkg::BUFFER_BYTES-1:0] buf_valid_r;
  logic [8:0] page_r;
  logic [PW-1:0] scan_r;

  wire wr_ctrl = sfr_req.wr && (sfr_req.addr == flash_prog_pkg::ADDR_CONTROL);
  wire wr_stat = sfr_req.wr && (sfr_req.addr == flash_prog_pkg::ADDR_STATUS);
  wire [3:0] wkey = sfr_req.wdata[7:4];
  wire [1:0] wsel = sfr_req.wdata[2:1];
  wire is_first = wr_ctrl && (wkey == flash_prog_pkg::KEY_FIRST);
  wire is_second = wr_ctrl && (wkey == flash_prog_pkg::KEY_SECOND);
  wire from_boot = (exec_region == flash_prog_pkg::REGION_BOOT);
  wire is_reset_op = (armed_sel_r == flash_prog_pkg::SEL_BUF_RESET);
  // A second key write is good only straight after a first key with the same select.
  wire seq_ok = is_second && armed_r && (wsel == armed_sel_r);
  // Only boot code may launch, and a write needs loaded data.
  wire launch_ok = seq_ok && from_boot && (loaded_r || is_reset_op) && (state_r == ST_IDLE);
  wire launch_bad = is_second && !launch_ok;
  // Boot flash is never a write target: space select only addresses user flash.
  wire buf_wr_ok = xdata_req.wr && ctrl_r.map_buffer && !ctrl_r.busy
                   && (exec_region != flash_prog_pkg::REGION_EXTERNAL);
  wire [PW-1:0] buf_idx = xdata_req.addr[PW-1:0];
  wire mc_tick = machine_cycle;
  wire launch_start = (state_r == ST_WAIT) && mc_tick
                      && (mc_cnt_r == 2'(flash_prog_pkg::LAUNCH_DELAY_MC - 1));
  wire prog_done = (state_r == ST_PROG) && (prog_cnt_r == '0);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
      armed_sel_r <= flash_prog_pkg::SEL_USER;
    end else if (instr_boundary || wr_ctrl) begin
      armed_r <= is_first;
      armed_sel_r <= wsel;
    end
  end

  seq_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (launch_ok) state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (launch_start) state_nxt = ST_PROG;
      end
      ST_PROG: begin
        if (prog_done) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      mc_cnt_r <= 2'h0;
      op_sel_r <= flash_prog_pkg::SEL_USER;
      prog_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (launch_ok) begin
        mc_cnt_r <= 2'h0;
        op_sel_r <= armed_sel_r;
      end else if ((state_r == ST_WAIT) && mc_tick) begin
        mc_cnt_r <= mc_cnt_r + 2'h1;
      end
      if (launch_start) begin
        prog_cnt_r <= (op_sel_r == flash_prog_pkg::SEL_BUF_RESET) ? '0 : CW'(PROGRAM_CYCLES - 1);
      end else if (prog_cnt_r != '0) begin
        prog_cnt_r <= prog_cnt_r - CW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy covers the launch delay as well, so the buffer is frozen from launch on.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= flash_prog_pkg::CONTROL_RESET;
      seq_err_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r.key <= wkey;
        ctrl_r.map_buffer <= sfr_req.wdata[3];
        ctrl_r.space_sel <= wsel;
      end
      ctrl_r.busy <= (state_nxt != ST_IDLE);
      // Hardware set wins over a software clear in the same cycle.
      if (launch_bad) seq_err_r <= 1'b1;
      else if (launch_ok) seq_err_r <= 1'b0;
      else if (wr_stat && !sfr_req.wdata[1]) seq_err_r <= 1'b0;
      if (buf_wr_ok) loaded_r <= 1'b1;
      else if (prog_done) loaded_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer storage has no read path to software.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_valid_r <= '0;
      page_r <= 9'h000;
    end else begin
      if (prog_done) buf_valid_r <= '0;
      else if (buf_wr_ok) buf_valid_r[buf_idx] <= 1'b1;
      if (buf_wr_ok) page_r <= xdata_req.addr[15:PW];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (buf_wr_ok) buf_data_r[buf_idx] <= xdata_req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One buffer byte goes out per clock while programming, looping over the page.
  wire prog_write = (state_r == ST_PROG) && (op_sel_r != flash_prog_pkg::SEL_BUF_RESET);
  // A security write keeps the fused lock field, so software can never loosen the lock.
  wire [7:0] scan_byte = buf_data_r[scan_r];
  wire [7:0] sec_keep = fuse_r & flash_prog_pkg::SECURITY_DEFINED & ~flash_prog_pkg::SECURITY_WRITABLE;
  wire [7:0] sec_merge = (scan_byte & flash_prog_pkg::SECURITY_WRITABLE) | sec_keep;
  wire [7:0] wdata_nxt = (op_sel_r == flash_prog_pkg::SEL_SECURITY) ? sec_merge : scan_byte;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scan_r <= '0;
      flash_write_strobe <= 1'b0;
      flash_write_space <= flash_prog_pkg::SEL_USER;
      flash_page_addr <= 9'h000;
      flash_wdata <= 8'h00;
      flash_wbyte <= 7'h00;
      flash_wbyte_valid <= 1'b0;
    end else begin
      scan_r <= prog_write ? scan_r + PW'(1) : '0;
      flash_write_strobe <= prog_write;
      flash_write_space <= op_sel_r;
      flash_page_addr <= page_r;
      flash_wdata <= wdata_nxt;
      flash_wbyte <= scan_r;
      flash_wbyte_valid <= prog_write && buf_valid_r[scan_r];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only the two top security bits are taken from the buffer; lock bits stay.
  wire [7:0] sec_view = fuse_r & flash_prog_pkg::SECURITY_DEFINED;
  wire [7:0] stat_view = {6'h00, seq_err_r, loaded_r};
  wire [7:0] sfr_rd_nxt = (sfr_req.addr == flash_prog_pkg::ADDR_CONTROL) ? ctrl_r
                        : (sfr_req.addr == flash_prog_pkg::ADDR_STATUS) ? stat_view : 8'h00;
  wire in_extra = (code_addr & flash_prog_pkg::EXTRA_ROW_BASE) == flash_prog_pkg::EXTRA_ROW_BASE;
  wire ext_locked = (exec_region == flash_prog_pkg::REGION_EXTERNAL) && (sec_view[2:0] != 3'h7);
  wire refuse_nxt = ext_locked
                  || ((ctrl_r.space_sel == flash_prog_pkg::SEL_EXTRA) && !in_extra)
                  || ((ctrl_r.space_sel == flash_prog_pkg::SEL_SECURITY)
                      && (code_addr != flash_prog_pkg::SECURITY_ADDR));
  wire [7:0] code_nxt = (ctrl_r.space_sel == flash_prog_pkg::SEL_SECURITY) ? sec_view
                      : user_flash_rdata;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      xdata_passthru <= 1'b0;
      code_rdata <= 8'h00;
      code_read_refused <= 1'b0;
      double_speed <= 1'b0;
      boot_map_enable <= 1'b0;
      start_addr <= flash_prog_pkg::START_USER;
      general_lock_field <= 3'h0;
    end else begin
      sfr_rdata <= sfr_rd_nxt;
      xdata_passthru <= xdata_req.wr && !ctrl_r.map_buffer;
      code_rdata <= refuse_nxt ? 8'h00 : code_nxt;
      code_read_refused <= refuse_nxt;
      double_speed <= !fuse_x2;
      boot_map_enable <= !fuse_jump;
      start_addr <= fuse_jump ? flash_prog_pkg::START_USER : flash_prog_pkg::START_BOOT;
      general_lock_field <= sec_view[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_busy_blocks_buf: assert property (@(posedge clk_sys) disable iff (!rst_n) (state_r != ST_IDLE) |-> !buf_wr_ok)
    else $error("buffer written while busy");
  a_bad_sets_err: assert property (@(posedge clk_sys) disable iff (!rst_n) launch_bad |=> seq_err_r)
    else $error("bad launch did not flag error");
  a_launch_busy: assert property (@(posedge clk_sys) disable iff (!rst_n) launch_ok |=> ctrl_r.busy)
    else $error("busy not set after launch");
  a_nonboot_no_launch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !from_boot |-> !launch_ok)
    else $error("launch from non-boot code");
  a_load_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) buf_wr_ok |=> loaded_r)
    else $error("loaded flag not set");
  a_done_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prog_done && !buf_wr_ok |=> !loaded_r && !ctrl_r.busy)
    else $error("completion did not clear flags");
  a_status_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(sfr_req.addr) == flash_prog_pkg::ADDR_STATUS |-> sfr_rdata[7:2] == 6'h00)
    else $error("status upper bits nonzero");
  a_ext_no_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    exec_region == flash_prog_pkg::REGION_EXTERNAL |-> !buf_wr_ok)
    else $error("external code loaded buffer");
  c_launch: cover property (@(posedge clk_sys) disable iff (!rst_n) launch_ok);
  c_bad: cover property (@(posedge clk_sys) disable iff (!rst_n) launch_bad);
  c_done: cover property (@(posedge clk_sys) disable iff (!rst_n) prog_done);
  // Checks from inputs to outputs look one cycle on, since every output is taken from a flop.
  a_idle_no_strobe: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl_r.busy |-> !prog_write)
    else $error("flash write while not busy");
  a_sec_lock_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prog_write && (op_sel_r == flash_prog_pkg::SEL_SECURITY) |=> flash_wdata[2:0] == general_lock_field)
    else $error("lock field taken from buffer");
  a_ext_read_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (exec_region == flash_prog_pkg::REGION_EXTERNAL) && (sec_view[2:0] != 3'h7) |=> code_read_refused)
    else $error("locked external read allowed");
  a_refused_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    code_read_refused |-> code_rdata == 8'h00)
    else $error("refused read returned data");
  a_split_keys_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_second && !armed_r |=> seq_err_r)
    else $error("unarmed second key not flagged");
  c_reset_op: cover property (@(posedge clk_sys) disable iff (!rst_n)
    prog_done && (op_sel_r == flash_prog_pkg::SEL_BUF_RESET));
  c_refused: cover property (@(posedge clk_sys) disable iff (!rst_n) code_read_refused);
endmodule
`default_nettype wire

// ### verif/cpu_side_model.sv
// CPU-side partner model: machine cycle stream and user flash array contents.
`default_nettype none
module cpu_side_model #(
  parameter int MC_CLOCKS = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] code_addr,
  output logic machine_cycle,
  output logic [7:0] user_flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mc_cnt_r;
  // Array content depends on the address, so a misrouted read cannot match by luck.
  assign user_flash_rdata = code_addr[7:0] ^ 8'h5a;
  assign machine_cycle = (mc_cnt_r == 4'h1);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mc_cnt_r <= 4'h0;
    end else if (mc_cnt_r == 4'(MC_CLOCKS - 1)) begin
      mc_cnt_r <= 4'h0;
    end else begin
      mc_cnt_r <= mc_cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the user flash program control block.
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, instr_boundary, machine_cycle;
  flash_prog_pkg::sfr_req_t sfr_req;
  flash_prog_pkg::xdata_req_t xdata_req;
  flash_prog_pkg::region_t exec_region;
  logic [7:0] security_fuses, user_flash_rdata, sfr_rdata, code_rdata, flash_wdata, rd;
  logic [15:0] code_addr, start_addr;
  logic xdata_passthru, code_read_refused, double_speed, boot_map_enable;
  logic flash_write_strobe, flash_wbyte_valid;
  logic [2:0] general_lock_field;
  logic [1:0] flash_write_space;
  logic [8:0] flash_page_addr;
  logic [6:0] flash_wbyte;
  int n_fail = 0;
  int total_checks = 0;
  user_flash_program_control #(.PROGRAM_CYCLES(20)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .sfr_req(sfr_req), .instr_boundary(instr_boundary), .machine_cycle(machine_cycle),
    .exec_region(exec_region), .xdata_req(xdata_req), .security_fuses(security_fuses),
    .code_addr(code_addr), .user_flash_rdata(user_flash_rdata), .sfr_rdata(sfr_rdata),
    .xdata_passthru(xdata_passthru), .code_rdata(code_rdata), .code_read_refused(code_read_refused),
    .double_speed(double_speed), .boot_map_enable(boot_map_enable), .start_addr(start_addr),
    .general_lock_field(general_lock_field), .flash_write_strobe(flash_write_strobe),
    .flash_write_space(flash_write_space), .flash_page_addr(flash_page_addr),
    .flash_wdata(flash_wdata), .flash_wbyte(flash_wbyte), .flash_wbyte_valid(flash_wbyte_valid));
  cpu_side_model cpu (.clk_sys(clk_sys), .rst_b(rst_b), .code_addr(code_addr),
    .machine_cycle(machine_cycle), .user_flash_rdata(user_flash_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] f);
    rst_b = 1'b0;
    security_fuses = f;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys) sfr_req = '{1'b1, a, d};
    @(negedge clk_sys) sfr_req.wr = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a);
    @(negedge clk_sys) sfr_req = '{1'b0, a, 8'h00};
    @(negedge clk_sys) rd = sfr_rdata;
  endtask
  task automatic xd_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys) xdata_req = '{1'b1, a, d};
    @(negedge clk_sys) xdata_req.wr = 1'b0;
  endtask
  // Both keys go out on consecutive cycles, with nothing in between.
  task automatic launch(input logic [7:0] k1, input logic [7:0] k2);
    @(negedge clk_sys) sfr_req = '{1'b1, flash_prog_pkg::ADDR_CONTROL, k1};
    @(negedge clk_sys) sfr_req.wdata = k2;
    @(negedge clk_sys) sfr_req.wr = 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      sfr_rd(flash_prog_pkg::ADDR_CONTROL);
      if (rd[0] === 1'b0) break;
    end
    `CHK(rd[0], 1'b0, "busy never cleared")
  endtask
  task automatic stat(input logic [7:0] e, input string m);
    sfr_rd(flash_prog_pkg::ADDR_STATUS);
    `CHK(rd, e, m)
  endtask
  task automatic code_rd(input logic [15:0] a, input logic [7:0] e, input logic r);
    @(negedge clk_sys) code_addr = a;
    @(negedge clk_sys);
    `CHK(code_read_refused, r, "code read refusal")
    `CHK(code_rdata, e, "code read data")
  endtask
  task automatic find_byte(input logic [6:0] b);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_sys);
      if (flash_write_strobe && flash_wbyte_valid && flash_wbyte == b) break;
    end
    `CHK(flash_wbyte_valid, 1'b1, "loaded byte never written")
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fuses();
    do_reset(8'h7f);
    `CHK(double_speed, 1'b1, "double speed off")
    `CHK(boot_map_enable, 1'b0, "boot map set")
    `CHK(start_addr, flash_prog_pkg::START_USER, "start not user")
    `CHK(general_lock_field, 3'h7, "lock field")
    do_reset(8'hb5);
    `CHK(double_speed, 1'b0, "double speed on")
    `CHK(boot_map_enable, 1'b1, "boot map clear")
    `CHK(start_addr, flash_prog_pkg::START_BOOT, "start not boot")
    `CHK(general_lock_field, 3'h5, "lock field")
    sfr_rd(flash_prog_pkg::ADDR_CONTROL);
    `CHK(rd, flash_prog_pkg::CONTROL_RESET, "control reset")
    stat(flash_prog_pkg::STATUS_RESET, "status reset");
  endtask
  task automatic t_hw_bits();
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h01);
    sfr_rd(flash_prog_pkg::ADDR_CONTROL);
    `CHK(rd[0], 1'b0, "busy written")
    sfr_wr(flash_prog_pkg::ADDR_STATUS, 8'hfc);
    stat(8'h00, "unused status bits");
  endtask
  task automatic t_code_read();
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h00);
    code_rd(16'h1234, 8'h34 ^ 8'h5a, 1'b0);
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h04);
    code_rd(16'h0000, 8'h85, 1'b0);
    code_rd(16'h0001, 8'h00, 1'b1);
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h02);
    code_rd(16'hff90, 8'h90 ^ 8'h5a, 1'b0);
    code_rd(16'h1234, 8'h00, 1'b1);
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h00);
    exec_region = flash_prog_pkg::REGION_EXTERNAL;
    code_rd(16'h1234, 8'h00, 1'b1);
    exec_region = flash_prog_pkg::REGION_BOOT;
  endtask
  task automatic t_program();
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h08);
    xd_wr(16'h1204, 8'hc3);
    `CHK(xdata_passthru, 1'b0, "write not captured")
    stat(8'h01, "loaded not set");
    launch(8'h58, 8'ha8);
    sfr_rd(flash_prog_pkg::ADDR_CONTROL);
    `CHK(rd[0], 1'b1, "busy not set")
    // A load during the launch delay must not replace the captured byte.
    xd_wr(16'h0004, 8'h11);
    find_byte(7'h04);
    `CHK(flash_wdata, 8'hc3, "program data")
    `CHK(flash_page_addr, 9'h024, "page address")
    `CHK(flash_write_space, flash_prog_pkg::SEL_USER, "space")
    @(negedge clk_sys);
    `CHK(flash_wbyte_valid, 1'b0, "unloaded byte written")
    wait_idle();
    stat(8'h00, "flags after write");
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h00);
    xd_wr(16'h1234, 8'h77);
    `CHK(xdata_passthru, 1'b1, "xdata not passed")
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h0c);
    xd_wr(16'h0000, 8'h3a);
    launch(8'h54, 8'ha4);
    find_byte(7'h00);
    `CHK(flash_wdata, 8'h05, "lock bits taken from buffer")
    `CHK(flash_write_space, flash_prog_pkg::SEL_SECURITY, "security space")
    wait_idle();
    stat(8'h00, "flags after security write");
  endtask
  task automatic t_errors();
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h08);
    xd_wr(16'h0100, 8'h5e);
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h58);
    @(negedge clk_sys) instr_boundary = 1'b1;
    @(negedge clk_sys) instr_boundary = 1'b0;
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'ha8);
    stat(8'h03, "split keys");
    sfr_wr(flash_prog_pkg::ADDR_STATUS, 8'h01);
    stat(8'h01, "error not cleared");
    launch(8'h58, 8'haa);
    stat(8'h03, "select mismatch");
    exec_region = flash_prog_pkg::REGION_USER;
    launch(8'h58, 8'ha8);
    sfr_rd(flash_prog_pkg::ADDR_CONTROL);
    `CHK(rd[0], 1'b0, "user code launched")
    exec_region = flash_prog_pkg::REGION_BOOT;
    launch(8'h56, 8'ha6);
    wait_idle();
    stat(8'h00, "buffer reset flags");
    launch(8'h50, 8'ha0);
    stat(8'h02, "empty buffer launch");
    sfr_wr(flash_prog_pkg::ADDR_STATUS, 8'h00);
    exec_region = flash_prog_pkg::REGION_EXTERNAL;
    sfr_wr(flash_prog_pkg::ADDR_CONTROL, 8'h08);
    xd_wr(16'h0200, 8'h33);
    stat(8'h00, "external load");
    exec_region = flash_prog_pkg::REGION_BOOT;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #(40 * 20000);
    n_fail++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    sfr_req = '{1'b0, 8'h00, 8'h00};
    xdata_req = '{1'b0, 16'h0000, 8'h00};
    exec_region = flash_prog_pkg::REGION_BOOT;
    instr_boundary = 1'b0;
    security_fuses = 8'hff;
    code_addr = 16'h0000;
    t_fuses();
    t_hw_bits();
    t_code_read();
    t_program();
    t_errors();
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
